// >>> rtl/tick_timer_pkg.sv
// package of offsets, fields, reset values and timing counts for the tick timer
package tick_timer_pkg;
	// ************************************************************
	// register offsets (byte addresses within the block)
	// ************************************************************
	localparam logic [7:0] OFS_CONTROL = 8'h10; // control and status
	localparam logic [7:0] OFS_RELOAD = 8'h14; // tick_reload_value
	localparam logic [7:0] OFS_LIVE = 8'h18; // tick_live_count
	localparam logic [7:0] OFS_CALIB = 8'h1C; // tick_calibration
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20; // sticky event bits
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24; // event mask
	// ************************************************************
	// field positions and widths
	// ************************************************************
	localparam int COUNT_W = 24; // live count and reload width
	localparam int BIT_ENABLE = 0; // control: run bit
	localparam int BIT_TICK_INT = 1; // control: tick_exception_enable
	localparam int BIT_CLK_SEL = 2; // control: count_clock_select
	localparam int BIT_COUNT_FLAG = 16; // control: counted-to-zero
	localparam int BIT_NO_REF = 31; // calibration: no_reference_flag
	localparam int BIT_INEXACT = 30; // calibration: calibration_inexact_flag
	localparam int IRQ_W = 1; // one event: wrap to zero
	// ************************************************************
	// reset values and constants
	// ************************************************************
	localparam logic NO_REF_RESET = 1'h0; // reference clock present
	localparam logic INEXACT_RESET = 1'h0; // value taken as exact
	localparam logic [23:0] TEN_MS_COUNT = 24'h0009C4; // ten_millisecond_count, not calibrated
	localparam logic [23:0] COUNT_RESET = 24'h000000; // undefined on power-up, zero chosen
	localparam int REF_DIVIDE = 32; // reference is oscillator over 32
	localparam logic [4:0] REF_DIV_LAST = 5'(REF_DIVIDE - 1); // divider terminal count
endpackage

// >>> rtl/tick_ref_divider.sv
// divide-by-32 enable pulse generator for the reference count clock
`timescale 1ns/1ps
module tick_ref_divider
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic osc_tick_in, // one pulse per oscillator period
	output logic ref_tick_out // one pulse per 32 oscillator periods
);
	logic [4:0] div_q; // prescale count
	// ************************************************************
	// prescaler
	// ************************************************************
	// count oscillator pulses, emit on the terminal one
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			div_q <= 5'h00;
		else if (osc_tick_in)
			div_q <= (div_q == tick_timer_pkg::REF_DIV_LAST) ? 5'h00 : div_q + 5'h01;
	end
	// pulse is combinational so it aligns with the oscillator tick
	assign ref_tick_out = osc_tick_in && (div_q == tick_timer_pkg::REF_DIV_LAST);
endmodule

// >>> rtl/system_tick_timer_regs.sv
// system tick timer with control, reload, live count and calibration registers on wishbone
`timescale 1ns/1ps
// Overview of operation
// - reload field bits 23-0, upper zero
// - live count readable in bits 23-0
// - any live-count write zeroes the count
// - live-count write also clears counted flag
// - calibration bit 31 reads zero, reference present
// - calibration bit 30 reads zero, exact
// - calibration low 24 bits read-only count
// - calibration bits 29-24 read zero
// - counted flag clears on control read
// - enabling loads reload and starts counting
// - clock select: reference/32 or cpu clock
// - tick enable pends exception at zero
module system_tick_timer_regs
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic osc_tick_in, // oscillator reference pulse
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	output logic tick_pend_out, // tick exception pend pulse
	output logic irq_out // level interrupt
);
	// ************************************************************
	// declarations
	// ************************************************************
	logic [23:0] count_q; // live count
	logic [23:0] reload_q; // reload value
	logic enable_q; // run bit
	logic tick_int_q; // tick_exception_enable
	logic clk_sel_q; // count_clock_select
	logic flag_q; // counted-to-zero
	logic [0:0] irq_stat_q; // sticky events
	logic [0:0] irq_mask_q; // event mask
	logic ack_q; // bus answer
	logic [31:0] rdata_q; // registered read data
	logic pend_q; // pend pulse register
	logic ref_tick; // reference count enable
	logic count_tick; // selected count enable
	logic access; // new bus cycle this edge
	logic wr; // write strobe
	logic rd; // read strobe
	logic wrap; // count leaving zero this tick
	logic enable_rise; // enable written from 0 to 1
	logic [31:0] rdata_d; // read mux
	logic [31:0] ctrl_word; // control read view
	logic [31:0] wmask; // byte-lane write mask
	logic [31:0] ctrl_new; // control after write
	// ************************************************************
	// count clock selection
	// ************************************************************
	tick_ref_divider u_div
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.osc_tick_in(osc_tick_in),
		.ref_tick_out(ref_tick)
	);
	assign count_tick = clk_sel_q ? 1'b1 : ref_tick;
	// checks: count clock source
	// reference gates counting
	a_ref_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!clk_sel_q && !ref_tick |-> !count_tick)
		else $error("count tick without reference");
	a_ref_single: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ref_tick |=> !ref_tick)
		else $error("reference pulse longer than one cycle");
	// ************************************************************
	// bus decode
	// ************************************************************
	// one request per cycle; ack after one wait so ack_q gates repeats
	assign access = wb_cyc_in && wb_stb_in && !ack_q;
	assign wr = access && wb_we_in;
	assign rd = access && !wb_we_in;
	// byte enables expanded to a bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			assign wmask[gi*8 +: 8] = {8{wb_sel_in[gi]}};
		end
	endgenerate
	assign ctrl_word = {15'h0000, flag_q, 13'h0000, clk_sel_q, tick_int_q, enable_q};
	assign ctrl_new = (ctrl_word & ~wmask) | (wb_dat_in & wmask);
	assign enable_rise = wr && (wb_adr_in == tick_timer_pkg::OFS_CONTROL) && !enable_q
		&& ctrl_new[tick_timer_pkg::BIT_ENABLE];
	assign wrap = enable_q && count_tick && (count_q == 24'h000000);
	// ************************************************************
	// control register
	// ************************************************************
	// run, interrupt enable and source select bits
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			enable_q <= 1'b0;
			tick_int_q <= 1'b0;
			clk_sel_q <= 1'b0;
		end
		else if (wr && wb_adr_in == tick_timer_pkg::OFS_CONTROL)
		begin
			enable_q <= ctrl_new[tick_timer_pkg::BIT_ENABLE];
			tick_int_q <= ctrl_new[tick_timer_pkg::BIT_TICK_INT];
			clk_sel_q <= ctrl_new[tick_timer_pkg::BIT_CLK_SEL];
		end
	end
	// checks: control register
	// control bits take write
	a_ctrl_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr && wb_adr_in == tick_timer_pkg::OFS_CONTROL && wb_sel_in[0]
		|=> enable_q == $past(wb_dat_in[tick_timer_pkg::BIT_ENABLE])
		&& tick_int_q == $past(wb_dat_in[tick_timer_pkg::BIT_TICK_INT])
		&& clk_sel_q == $past(wb_dat_in[tick_timer_pkg::BIT_CLK_SEL]))
		else $error("control bits not written");
	// ************************************************************
	// reload register
	// ************************************************************
	// undefined at power-up in the part; zero here for determinism
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			reload_q <= tick_timer_pkg::COUNT_RESET;
		else if (wr && wb_adr_in == tick_timer_pkg::OFS_RELOAD)
			reload_q <= (reload_q & ~wmask[23:0]) | (wb_dat_in[23:0] & wmask[23:0]);
	end
	// checks: reload register
	// full-lane write stores field
	a_reload_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr && wb_adr_in == tick_timer_pkg::OFS_RELOAD && wb_sel_in == 4'hF
		|=> reload_q == $past(wb_dat_in[23:0]))
		else $error("reload field not stored");
	// ************************************************************
	// live counter
	// ************************************************************
	// live write beats enable load, which beats counting
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			count_q <= tick_timer_pkg::COUNT_RESET;
		else if (wr && wb_adr_in == tick_timer_pkg::OFS_LIVE)
			count_q <= 24'h000000;
		else if (enable_rise)
			count_q <= reload_q;
		else if (wrap)
			count_q <= reload_q;
		else if (enable_q && count_tick)
			count_q <= count_q - 24'h000001;
	end
	// checks: live counter
	// write forces zero
	a_live_write_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr && wb_adr_in == tick_timer_pkg::OFS_LIVE |=> count_q == 24'h000000)
		else $error("live write did not zero count");
	a_enable_loads: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		enable_rise |=> enable_q && count_q == $past(reload_q))
		else $error("enable did not load reload");
	a_disabled_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!enable_q && !access |=> $stable(count_q))
		else $error("count moved while stopped");
	a_count_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		enable_q && count_tick && count_q != 24'h000000 && !access
		|=> count_q == $past(count_q) - 24'h000001)
		else $error("count did not step down");
	a_wrap_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wrap && !(wr && wb_adr_in == tick_timer_pkg::OFS_LIVE) |=> count_q == $past(reload_q))
		else $error("count not reloaded at wrap");
	// ************************************************************
	// counted-to-zero flag
	// ************************************************************
	// a wrap in the clearing cycle wins so no event is lost
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			flag_q <= 1'b0;
		else if (wrap)
			flag_q <= 1'b1;
		else if (rd && wb_adr_in == tick_timer_pkg::OFS_CONTROL)
			flag_q <= 1'b0;
		else if (wr && wb_adr_in == tick_timer_pkg::OFS_LIVE)
			flag_q <= 1'b0;
	end
	// checks: counted-to-zero flag
	// live write clears flag
	a_live_write_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr && wb_adr_in == tick_timer_pkg::OFS_LIVE && !wrap |=> !flag_q)
		else $error("flag not cleared by live write");
	a_read_clears_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd && wb_adr_in == tick_timer_pkg::OFS_CONTROL && !wrap |=> !flag_q)
		else $error("control read did not clear flag");
	// ************************************************************
	// exception pend and interrupt
	// ************************************************************
	// pend on wrap
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pend_q <= 1'b0;
		else
			pend_q <= wrap && tick_int_q;
	end
	assign tick_pend_out = pend_q;
	// checks: exception pend
	// pend follows tick enable
	a_pend_on_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wrap |=> tick_pend_out == $past(tick_int_q) && flag_q)
		else $error("pend or flag wrong at wrap");
	a_no_pend_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!tick_int_q |=> !tick_pend_out)
		else $error("pend while tick exception disabled");
	// sticky status, write one to clear, set wins
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_stat_q <= 1'b0;
		else if (wrap)
			irq_stat_q <= 1'b1;
		else if (wr && wb_adr_in == tick_timer_pkg::OFS_IRQ_STATUS && wb_sel_in[0] && wb_dat_in[0])
			irq_stat_q <= 1'b0;
	end
	// mask: one enables the event onto irq_out
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_mask_q <= 1'b0;
		else if (wr && wb_adr_in == tick_timer_pkg::OFS_IRQ_MASK && wb_sel_in[0])
			irq_mask_q <= wb_dat_in[0];
	end
	assign irq_out = |(irq_stat_q & irq_mask_q);
	// checks: interrupt status and mask
	// a wrap always marks the status bit, whatever the mask
	a_status_on_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in) // status set
		wrap |=> irq_stat_q[0])
		else $error("status not set at wrap");
	// write one clears unless a wrap lands in the same cycle
	a_status_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // status clear
		wr && wb_adr_in == tick_timer_pkg::OFS_IRQ_STATUS && wb_sel_in[0] && wb_dat_in[0] && !wrap
		|=> !irq_stat_q[0])
		else $error("status not cleared by write one");
	// mask follows lane 0 writes
	a_mask_write: assert property (@(posedge clk_in) disable iff (!rst_n_in) // mask write
		wr && wb_adr_in == tick_timer_pkg::OFS_IRQ_MASK && wb_sel_in[0]
		|=> irq_mask_q[0] == $past(wb_dat_in[0]))
		else $error("mask not written");
	// ************************************************************
	// read mux and answer
	// ************************************************************
	// unregistered view, captured into rdata_q only on a read
	always_comb
	begin
		rdata_d = 32'h00000000;
		case (wb_adr_in)
			tick_timer_pkg::OFS_CONTROL: rdata_d = ctrl_word;
			tick_timer_pkg::OFS_RELOAD: rdata_d = {8'h00, reload_q};
			tick_timer_pkg::OFS_LIVE: rdata_d = {8'h00, count_q};
			tick_timer_pkg::OFS_CALIB: rdata_d = {tick_timer_pkg::NO_REF_RESET,
				tick_timer_pkg::INEXACT_RESET, 6'h00, tick_timer_pkg::TEN_MS_COUNT};
			tick_timer_pkg::OFS_IRQ_STATUS: rdata_d = {31'h00000000, irq_stat_q};
			tick_timer_pkg::OFS_IRQ_MASK: rdata_d = {31'h00000000, irq_mask_q};
			// unmapped offsets read zero and still ack
			default: rdata_d = 32'h00000000;
		endcase
	end
	// ack one cycle after the request, dropped next cycle
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= access;
			if (rd)
				rdata_q <= rdata_d;
		end
	end
	assign wb_ack_out = ack_q;
	assign wb_dat_out = rdata_q;
	// checks: read data
	// reload read upper zero
	a_reload_upper_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ack_q && $past(rd) && $past(wb_adr_in) == tick_timer_pkg::OFS_RELOAD |-> wb_dat_out[31:24] == 8'h00)
		else $error("reload upper bits not zero");
	a_live_read_value: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd && wb_adr_in == tick_timer_pkg::OFS_LIVE |=> wb_dat_out == {8'h00, $past(count_q)})
		else $error("live read wrong");
	a_calib_top_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd && wb_adr_in == tick_timer_pkg::OFS_CALIB |=> wb_dat_out[31:24] == 8'h00)
		else $error("calibration flags wrong");
	a_calib_calibration_inexact_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd && wb_adr_in == tick_timer_pkg::OFS_CALIB
		|=> wb_dat_out[tick_timer_pkg::BIT_INEXACT] == tick_timer_pkg::INEXACT_RESET)
		else $error("calibration inexact flag wrong");
	a_calib_mid_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd && wb_adr_in == tick_timer_pkg::OFS_CALIB |=> wb_dat_out[29:24] == 6'h00)
		else $error("calibration reserved bits not zero");
	a_calib_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rd && wb_adr_in == tick_timer_pkg::OFS_CALIB |=> wb_dat_out[23:0] == tick_timer_pkg::TEN_MS_COUNT)
		else $error("calibration count wrong");
	// read data stands until the next read, writes leave it alone
	a_dat_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in) // read hold
		!rd |=> $stable(wb_dat_out))
		else $error("read data changed without a read");
	// checks: bus answer
	// ack_q also blocks a second take of the request still held
	a_ack_after_take: assert property (@(posedge clk_in) disable iff (!rst_n_in) // bus answer
		access |=> ack_q)
		else $error("request not answered next cycle");
	// ack is a single-cycle pulse
	a_ack_single: assert property (@(posedge clk_in) disable iff (!rst_n_in) // bus answer
		ack_q |=> !ack_q)
		else $error("ack held longer than one cycle");
endmodule

// >>> dv/testbench.sv
// self-checking bench for the tick timer register block over classic wishbone
`timescale 1ns/1ps
module testbench;
	// ************************************************************
	// stimulus and observation signals
	// ************************************************************
	logic clk_in = 1'b0; // 20 MHz clock
	logic rst_n_in = 1'b0; // async reset, active low
	logic osc_tick_in = 1'b0; // reference pulse into the divider
	logic osc_run = 1'b0; // gates the reference pulse train
	logic wb_cyc_in = 1'b0;
	logic wb_stb_in = 1'b0;
	logic wb_we_in = 1'b0;
	logic [7:0] wb_adr_in = 8'h00;
	logic [3:0] wb_sel_in = 4'h0;
	logic [31:0] wb_dat_in = 32'h00000000;
	logic [31:0] wb_dat_out;
	logic wb_ack_out;
	logic tick_pend_out;
	logic irq_out;
	int fail_count = 0; // mismatches seen
	int comparisons = 0; // checks made
	int cycle_n = 0; // free-running cycle count
	int pend_n = 0; // pend pulses seen
	int take_cyc; // cycle at which the last ack was taken
	int t0;
	int p0;
	logic [31:0] rd; // data of the last read
	logic [31:0] r0;
	logic [3:0] sel_use = 4'hF; // byte lanes for the next transfer
	// 50 ns period
	always #25 clk_in = ~clk_in;
	// cycle count, reference pulses every cycle while gated on, pend pulse tally
	always @(posedge clk_in)
	begin
		cycle_n <= cycle_n + 1;
		osc_tick_in <= osc_run;
		if (tick_pend_out === 1'b1)
			pend_n <= pend_n + 1;
	end
	system_tick_timer_regs dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .osc_tick_in(osc_tick_in),
		.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
		.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.tick_pend_out(tick_pend_out), .irq_out(irq_out));
	// ************************************************************
	// bus and check tasks
	// ************************************************************
	// one classic cycle; request held until ack is sampled, then released
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= adr;
		wb_sel_in <= sel_use;
		wb_dat_in <= dat;
		do
		begin
			@(posedge clk_in);
		end
		// no answer time assumed: a missing ack is left to the watchdog
		while (wb_ack_out !== 1'b1);
		rd = wb_dat_out;
		take_cyc = cycle_n;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		wb_xfer(1'b0, adr, 32'h00000000);
		check(rd, exp);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic end_sim();
		$display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ************************************************************
	// test sequence
	// ************************************************************
	// watchdog: the whole sequence needs well under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		end_sim();
	end
	initial
	begin
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		// reset values, calibration word, unmapped place
		rd_chk(tick_timer_pkg::OFS_CONTROL, 32'h00000000);
		rd_chk(tick_timer_pkg::OFS_RELOAD, {8'h00, tick_timer_pkg::COUNT_RESET});
		rd_chk(tick_timer_pkg::OFS_LIVE, {8'h00, tick_timer_pkg::COUNT_RESET});
		rd_chk(tick_timer_pkg::OFS_IRQ_STATUS, 32'h00000000);
		wb_xfer(1'b1, tick_timer_pkg::OFS_CALIB, 32'hFFFFFFFF);
		wb_xfer(1'b1, 8'h00, 32'hFFFFFFFF);
		rd_chk(tick_timer_pkg::OFS_CALIB, {tick_timer_pkg::NO_REF_RESET, tick_timer_pkg::INEXACT_RESET, 6'h00,
			tick_timer_pkg::TEN_MS_COUNT});
		rd_chk(8'h00, 32'h00000000);
		// reload field width: upper byte reads zero
		wb_xfer(1'b1, tick_timer_pkg::OFS_RELOAD, 32'hFFFFFFFF);
		rd_chk(tick_timer_pkg::OFS_RELOAD, 32'h00FFFFFF);
		$display("test reset and field widths done");
		// cpu clock counting with exception pend and unmasked interrupt
		wb_xfer(1'b1, tick_timer_pkg::OFS_RELOAD, 32'h00000100);
		wb_xfer(1'b1, tick_timer_pkg::OFS_IRQ_MASK, 32'h00000001);
		wb_xfer(1'b1, tick_timer_pkg::OFS_CONTROL, 32'h00000007);
		wb_xfer(1'b0, tick_timer_pkg::OFS_LIVE, 32'h00000000);
		r0 = rd;
		t0 = take_cyc;
		check(32'(r0 > 32'h000000F0 && r0 <= 32'h00000100), 32'h00000001);
		wb_xfer(1'b0, tick_timer_pkg::OFS_LIVE, 32'h00000000);
		// one decrement per cycle between the two sampling edges
		check(rd, r0 - 32'(take_cyc - t0));
		wait_cyc(300);
		check(32'(irq_out), 32'h00000001);
		check(32'(pend_n > 0), 32'h00000001);
		rd_chk(tick_timer_pkg::OFS_CONTROL, 32'h00010007);
		rd_chk(tick_timer_pkg::OFS_CONTROL, 32'h00000007);
		rd_chk(tick_timer_pkg::OFS_IRQ_STATUS, 32'h00000001);
		wb_xfer(1'b1, tick_timer_pkg::OFS_IRQ_STATUS, 32'h00000001);
		rd_chk(tick_timer_pkg::OFS_IRQ_STATUS, 32'h00000000);
		check(32'(irq_out), 32'h00000000);
		$display("test cpu clock counting done");
		// no pend with tick exception off, masked interrupt, live count clear
		wb_xfer(1'b1, tick_timer_pkg::OFS_IRQ_MASK, 32'h00000000);
		wb_xfer(1'b1, tick_timer_pkg::OFS_CONTROL, 32'h00000005);
		p0 = pend_n;
		wait_cyc(300);
		check(32'(pend_n), 32'(p0));
		check(32'(irq_out), 32'h00000000);
		rd_chk(tick_timer_pkg::OFS_IRQ_STATUS, 32'h00000001);
		wb_xfer(1'b1, tick_timer_pkg::OFS_CONTROL, 32'h00000000);
		wb_xfer(1'b1, tick_timer_pkg::OFS_LIVE, 32'hFFFFFFFF);
		rd_chk(tick_timer_pkg::OFS_LIVE, 32'h00000000);
		rd_chk(tick_timer_pkg::OFS_CONTROL, 32'h00000000);
		wb_xfer(1'b1, tick_timer_pkg::OFS_IRQ_STATUS, 32'h00000001);
		$display("test live count clear done");
		// reference clock: frozen without pulses, one step per 32 pulses
		wb_xfer(1'b1, tick_timer_pkg::OFS_RELOAD, 32'h00000002);
		wb_xfer(1'b1, tick_timer_pkg::OFS_CONTROL, 32'h00000001);
		rd_chk(tick_timer_pkg::OFS_LIVE, 32'h00000002);
		osc_run <= 1'b1;
		wait_cyc(10);
		rd_chk(tick_timer_pkg::OFS_LIVE, 32'h00000002);
		// first reference step after 32 pulses, the second after 64
		wait_cyc(40);
		rd_chk(tick_timer_pkg::OFS_LIVE, 32'h00000001);
		wait_cyc(100);
		rd_chk(tick_timer_pkg::OFS_CONTROL, 32'h00010001);
		// byte lanes: only lane 0 of the reload field is written
		sel_use = 4'h1;
		wb_xfer(1'b1, tick_timer_pkg::OFS_RELOAD, 32'h12345678);
		sel_use = 4'hF;
		rd_chk(tick_timer_pkg::OFS_RELOAD, 32'h00000078);
		$display("test reference clock done");
		end_sim();
	end
endmodule
